// ===== design/adc_output_timing.sv
`timescale 1ns/1ps
`include "adc_consts.svh"

module adc_output_timing (
   // Clock and reset
   input wire logic i_ref_clk,
   input wire logic i_rst_n,
   // Stage decisions and control pins
   input wire adc_pkg::stage_dec_t i_stage_dec,
   input wire adc_pkg::ctrl_pins_t i_ctrl,
   input wire logic i_output_enable_n,
   // Data bus and status
   output logic [`ADC_WORD_W-1:0] o_data,
   output logic o_data_oe,
   output logic o_data_valid,
   output logic o_core_active,
   output logic o_int_ref_on
);

   // Whole core state, registered as one word
   typedef struct packed {
      logic standby_meta;
      logic standby_sync;
      logic refpd_meta;
      logic refpd_sync;
      logic [`ADC_FILL_W-1:0] fill;
      logic valid;
      logic [`ADC_WORD_W-1:0] word;
   } core_state_t;

   // Registered state and its next value
   core_state_t st;
   core_state_t next_st;
   // Stage codes lined up on one edge, one driver per stage
   wire adc_pkg::stage_dec_t aligned;

   // ==========================================================
   // Stage alignment
   // Stage j arrives at edge j/2 after sampling starts; earlier
   // stages wait longer so all codes line up at edge 4.
   genvar j;
   generate
      for (j = 0; j < `ADC_STAGE_CNT; j++) begin : g_align
         adc_align_delay #(
            .DEPTH(`ADC_ALIGN_BASE - j / 2)
         ) u_delay (
            .i_ref_clk(i_ref_clk),
            .i_rst_n(i_rst_n),
            .i_code(i_stage_dec.code[j]),
            .o_code(aligned.code[j])
         );
      end
   endgenerate

   // ==========================================================
   // Next-state logic
   always_comb begin
      next_st = st;
      // pin levels pass two flops before use
      next_st.standby_meta = i_ctrl.standby_request;
      next_st.standby_sync = st.standby_meta;
      next_st.refpd_meta = i_ctrl.reference_power_down;
      next_st.refpd_sync = st.refpd_meta;
      // fill count, valid held once pipeline is full
      // Standby restarts the count so valid waits for a full pipe
      if (st.standby_sync) begin
         next_st.fill = `ADC_FILL_RST;
      end else if (st.fill != `ADC_FILL_CYCLES) begin
         next_st.fill = st.fill + 3'h1;
      end
      next_st.valid = !st.standby_sync && (next_st.fill == `ADC_FILL_CYCLES);
      // output register closes the 4.5 cycle latency
      // straight binary from corrected sum
      // Word freezes in standby so the bus keeps the last sample
      if (!st.standby_sync) begin
         next_st.word = adc_pkg::correct_word(aligned);
      end
   end

   // ==========================================================
   // single rising-edge state register
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         st.standby_meta <= 1'b0;
         st.standby_sync <= 1'b0;
         st.refpd_meta <= 1'b0;
         st.refpd_sync <= 1'b0;
         st.fill <= `ADC_FILL_RST;
         st.valid <= 1'b0;
         st.word <= `ADC_WORD_RST;
      end else begin
         st <= next_st;
      end
   end

   // ==========================================================
   // Outputs
   assign o_data = st.word;
   // asynchronous enable, no clock in the path
   assign o_data_oe = !i_output_enable_n;
   assign o_data_valid = st.valid;
   // low pins keep core and internal references on
   assign o_core_active = !st.standby_sync;
   assign o_int_ref_on = !st.refpd_sync;

   // ==========================================================
   // Checks: latency and alignment
   // Word matches the stage codes taken two to five edges back
   a_latency_word: assert property (
      @(posedge i_ref_clk) disable iff (!i_rst_n)
      o_data_valid |-> o_data == adc_pkg::correct_word({
         $past(i_stage_dec.code[6], 2),
         $past(i_stage_dec.code[5], 3), $past(i_stage_dec.code[4], 3),
         $past(i_stage_dec.code[3], 4), $past(i_stage_dec.code[2], 4),
         $past(i_stage_dec.code[1], 5), $past(i_stage_dec.code[0], 5)}))
      else $error("output word not at fixed latency");

   // Aligned codes reach the word on the next edge
   a_align_word: assert property (
      @(posedge i_ref_clk) disable iff (!i_rst_n)
      !st.standby_sync |=> o_data == adc_pkg::correct_word($past(aligned)))
      else $error("aligned codes not combined");

   // Word and valid come straight from the rising-edge register
   a_fall_stable: assert property (
      @(negedge i_ref_clk) disable iff (!i_rst_n)
      o_data == st.word && o_data_valid == st.valid)
      else $error("output word moved on a falling edge");

   // ==========================================================
   // Checks: stream continuity and standby
   // Valid never drops while the core stays active
   a_no_gap: assert property (
      @(posedge i_ref_clk) disable iff (!i_rst_n)
      o_data_valid && !st.standby_sync |=> o_data_valid)
      else $error("valid word stream has a gap");

   // Four empty edges after standby, then words
   a_fill_time: assert property (
      @(posedge i_ref_clk) disable iff (!i_rst_n)
      $fell(st.standby_sync) |-> !o_data_valid [*4] ##1 o_data_valid)
      else $error("pipeline fill time wrong");

   // Standby holds the last word on the bus
   a_standby_hold: assert property (
      @(posedge i_ref_clk) disable iff (!i_rst_n)
      st.standby_sync |=> $stable(o_data))
      else $error("word moved during standby");

   // Standby withdraws valid on the next edge
   a_standby_drop: assert property (
      @(posedge i_ref_clk) disable iff (!i_rst_n)
      st.standby_sync |=> !o_data_valid)
      else $error("valid stayed high in standby");

   // ==========================================================
   // Checks: control pins and code range
   // Two low samples of both pins give active mode
   a_default_active: assert property (
      @(posedge i_ref_clk) disable iff (!i_rst_n)
      (!i_ctrl.standby_request && !i_ctrl.reference_power_down) [*2]
      |=> o_core_active && o_int_ref_on)
      else $error("low control pins did not give active mode");

   // Standby pin reaches the status after two flops
   a_standby_enter: assert property (
      @(posedge i_ref_clk) disable iff (!i_rst_n)
      $rose(i_ctrl.standby_request) |-> ##1 o_core_active ##1 !o_core_active)
      else $error("standby entry delay wrong");

   // Standby release reaches the status after two flops
   a_standby_leave: assert property (
      @(posedge i_ref_clk) disable iff (!i_rst_n)
      $fell(i_ctrl.standby_request) |-> ##1 !o_core_active ##1 o_core_active)
      else $error("standby exit delay wrong");

   // Reference power-down reaches the status after two flops
   a_refpd_enter: assert property (
      @(posedge i_ref_clk) disable iff (!i_rst_n)
      $rose(i_ctrl.reference_power_down) |-> ##1 o_int_ref_on ##1 !o_int_ref_on)
      else $error("reference power-down delay wrong");

   // Reference restore reaches the status after two flops
   a_refpd_leave: assert property (
      @(posedge i_ref_clk) disable iff (!i_rst_n)
      $fell(i_ctrl.reference_power_down) |-> ##1 !o_int_ref_on ##1 o_int_ref_on)
      else $error("reference restore delay wrong");

   // All-zero decisions give the bottom code
   a_binary_ends: assert property (
      @(posedge i_ref_clk) disable iff (!i_rst_n)
      !st.standby_sync && aligned == '0 |=> o_data == 8'h00)
      else $error("bottom code is not zero");

   // All-high decisions clamp to the top code
   a_binary_top: assert property (
      @(posedge i_ref_clk) disable iff (!i_rst_n)
      !st.standby_sync && aligned == '1 |=> o_data == 8'hff)
      else $error("top code is not full scale");

   // ==========================================================
   // Checks: output enable
   // Raising the enable pin releases the bus at once
   a_oe_async: assert property (
      @(posedge i_ref_clk) disable iff (!i_rst_n)
      $rose(i_output_enable_n) |-> !o_data_oe ##1 $stable(o_data_oe) || $changed(i_output_enable_n))
      else $error("output enable did not release the bus");

   // High enable pin keeps the drivers off
   a_oe_release: assert property (
      @(posedge i_ref_clk) disable iff (!i_rst_n)
      i_output_enable_n |-> !o_data_oe)
      else $error("bus driven while enable pin high");

   // Low enable pin keeps the drivers on
   a_oe_drive: assert property (
      @(posedge i_ref_clk) disable iff (!i_rst_n)
      !i_output_enable_n |-> o_data_oe)
      else $error("bus floating while enable pin low");

endmodule

// ===== design/adc_consts.svh
`ifndef ADC_CONSTS_SVH
`define ADC_CONSTS_SVH

// ==========================================================
// Word and stage geometry
`define ADC_WORD_W 8
`define ADC_STAGE_CNT 7
`define ADC_CODE_W 2
`define ADC_FLASH_IDX 6

// ==========================================================
// Pipeline timing in clock cycles of i_ref_clk (latency in half cycles, fill counter width in bits)
`define ADC_LATENCY_HALVES 9
`define ADC_ALIGN_BASE 4
`define ADC_FILL_CYCLES 3'h4
`define ADC_FILL_W 3

// ==========================================================
// Reset values and word clamp limit
`define ADC_WORD_RST 8'h00
`define ADC_FILL_RST 3'h0
`define ADC_CODE_RST 2'h0
`define ADC_WORD_MAX 9'h0ff

`endif

// ===== design/adc_pkg.sv
`include "adc_consts.svh"

package adc_pkg;

   // Raw decisions of the six redundant stages and the final flash
   typedef struct packed {
      logic [`ADC_STAGE_CNT-1:0][`ADC_CODE_W-1:0] code;
   } stage_dec_t;

   // Pin-side control levels, pulled low by default outside the core
   typedef struct packed {
      logic standby_request;
      logic reference_power_down;
   } ctrl_pins_t;

   // Digital correction: overlap-add of the stage decisions, clamped
   function automatic logic [`ADC_WORD_W-1:0] correct_word(input stage_dec_t dec);
      logic [`ADC_WORD_W:0] sum;
      sum = {7'h00, dec.code[`ADC_FLASH_IDX]};
      for (int j = 0; j < `ADC_FLASH_IDX; j++) begin
         sum = sum + ({7'h00, dec.code[j]} << (`ADC_FLASH_IDX - j));
      end
      if (sum > `ADC_WORD_MAX) begin
         sum = `ADC_WORD_MAX;
      end
      return sum[`ADC_WORD_W-1:0];
   endfunction

endpackage

// ===== design/adc_align_delay.sv
`timescale 1ns/1ps
`include "adc_consts.svh"

// Fixed-depth shift line that delays one stage decision
module adc_align_delay #(
   parameter int DEPTH = 1
) (
   input wire logic i_ref_clk,
   input wire logic i_rst_n,
   input wire logic [`ADC_CODE_W-1:0] i_code,
   output logic [`ADC_CODE_W-1:0] o_code
);

   typedef struct packed {
      logic [DEPTH-1:0][`ADC_CODE_W-1:0] tap;
   } delay_state_t;

   delay_state_t st;
   delay_state_t next_st;

   // ==========================================================
   // Shift one tap per rising edge
   always_comb begin
      next_st = st;
      next_st.tap[0] = i_code;
      for (int k = 1; k < DEPTH; k++) begin
         next_st.tap[k] = st.tap[k-1];
      end
   end

   // Tap register, cleared by reset
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign o_code = st.tap[DEPTH-1];

endmodule

// ===== dv/adc_capture_model.sv
`timescale 1ns/1ps
// Far-side logic that latches the parallel sample word
module adc_capture_model (
   input wire logic i_ref_clk,
   input wire logic [7:0] i_data,
   input wire logic i_data_oe,
   output logic [7:0] o_word
);
   // Pins float while the drivers are off
   wire [7:0] pins = i_data_oe ? i_data : 8'hzz;
   always @(negedge i_ref_clk) begin
      o_word <= pins;
   end
endmodule

// ===== dv/testbench.sv
`timescale 1ns/1ps
module testbench;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   adc_pkg::stage_dec_t dec = '0;
   adc_pkg::ctrl_pins_t ctrl = '0;
   logic oe_n = 1'b0;
   logic [7:0] data;
   logic [7:0] cap;
   logic oe, valid, active, ref_on;
   int num_errors = 0;
   int n_checks = 0;
   adc_pkg::stage_dec_t smp [8];

   // Conversion clock, 40 ns period
   always #20 clk = ~clk;

   adc_output_timing dut_u (.i_ref_clk(clk), .i_rst_n(rst_n), .i_stage_dec(dec),
      .i_ctrl(ctrl), .i_output_enable_n(oe_n), .o_data(data), .o_data_oe(oe),
      .o_data_valid(valid), .o_core_active(active), .o_int_ref_on(ref_on));
   adc_capture_model cap_u (.i_ref_clk(clk), .i_data(data), .i_data_oe(oe), .o_word(cap));

   // ==========================================================
   // Helpers
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      n_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask

   function automatic logic [1:0] code_of(input int s, input int j);
      return (s >= 0 && s < 8) ? smp[s].code[j] : 2'h0;
   endfunction

   function automatic logic [7:0] word_of(input int s);
      int sum = 0;
      for (int j = 0; j < 7; j++) begin
         sum += (j == 6) ? code_of(s, j) : code_of(s, j) << (6 - j);
      end
      return (sum > 255) ? 8'hff : sum[7:0];
   endfunction

   task automatic end_sim();
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   // ==========================================================
   // Scenarios
   task automatic reset_test();
      chk("reset word", 8'h00, data);
      chk("reset valid", 8'h00, {7'h00, valid});
      chk("default levels", 8'h07, {5'h00, active, ref_on, oe});
   endtask

   task automatic stream_test();
      for (int n = 0; n < 14; n++) begin
         @(negedge clk);
         for (int j = 0; j < 7; j++) dec.code[j] <= code_of(n - j / 2, j);
         #1;
         if (n >= 5) chk("word", word_of(n - 5), cap);
         if (n >= 5) chk("valid", 8'h01, {7'h00, valid});
         if (n == 1) chk("fill", 8'h00, {7'h00, valid});
      end
   endtask

   task automatic standby_test();
      logic [7:0] held;
      @(negedge clk);
      dec <= '1;
      ctrl.standby_request <= 1'b1;
      repeat (4) @(negedge clk);
      held = data;
      dec <= '0;
      repeat (4) @(negedge clk);
      chk("standby", 8'h00, {6'h00, active, valid});
      chk("frozen", held, data);
      ctrl.standby_request <= 1'b0;
      repeat (3) @(negedge clk);
      chk("refill", 8'h02, {6'h00, active, valid});
      repeat (7) @(negedge clk);
      chk("resume", 8'h03, {6'h00, active, valid});
   endtask

   task automatic refpd_test();
      @(negedge clk);
      ctrl.reference_power_down <= 1'b1;
      repeat (3) @(negedge clk);
      chk("ref off", 8'h02, {6'h00, active, ref_on});
      ctrl.reference_power_down <= 1'b0;
      repeat (3) @(negedge clk);
      chk("ref on", 8'h03, {6'h00, active, ref_on});
   endtask

   task automatic oe_test();
      @(negedge clk);
      oe_n <= 1'b1;
      #1 chk("disable", 8'h00, {7'h00, oe});
      @(negedge clk);
      #1 chk("floating", 8'hzz, cap);
      @(negedge clk);
      oe_n <= 1'b0;
      #1 chk("enable", 8'h01, {7'h00, oe});
      @(negedge clk);
      #1 chk("restored", 8'h00, cap);
   endtask

   // ==========================================================
   // Main sequence
   initial begin
      for (int s = 0; s < 8; s++) begin
         for (int j = 0; j < 7; j++) smp[s].code[j] = 2'((j == 6) ? s % 4 : (s + j) % 3);
      end
      smp[0] = '0;
      smp[1].code = {2'h3, {6{2'h2}}};
      smp[2] = '1;
      repeat (8) @(negedge clk);
      reset_test();
      rst_n <= 1'b1;
      stream_test();
      standby_test();
      refpd_test();
      oe_test();
      end_sim();
   end

   // Watchdog against a hang
   initial begin
      #40000;
      num_errors++;
      end_sim();
   end
endmodule
